// ==== rtl/cmr_top.sv ====
`timescale 1ns/1ps
// message ram layout: section config, event fifo pointers, parity, rx elements
// Operation
// - ack loads get index plus one, refills
// - ram is 32-bit words, all messages
// - ram holds at most 1600 words
// - sections optional, any order
// - filter sections 128 std, 64 ext
// - rx fifos and buffers 64 elements
// - event fifo 32 elements, two words
// - tx buffer section 32 elements
// - start addresses word aligned, low bits ignored
// - no configuration checking beyond clipping counts to maxima
// - parity mismatch on read sets flag
// - fd ram size from element sizes
// - 64 rx buffers, two 64-deep fifos
// - element size config up to 64 bytes
// - second word low half is timestamp
// - data words follow from third word
// - first word esi, xtd, rtr, id
// - second word nonmatching_accepted, filter_index, fdf, brs, dlc
// - dlc codes map to byte counts
module cmr_top #(
   parameter int WORDS = cmr_pkg::RAM_WORDS
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   // register port
   input wire logic [11:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // protocol engine side
   input wire cmr_pkg::cmr_wr_s eng_wr_i,
   input wire logic ev_push_i,
   input wire logic [15:0] ts_cnt_i,
   input wire cmr_pkg::cmr_hdr0_s hdr0_i,
   input wire cmr_pkg::cmr_hdr1_s hdr1_i,
   output logic [31:0] hdr0_word_o,
   output logic [31:0] hdr1_word_o,
   output logic [6:0] dlc_bytes_o,
   output logic [4:0] event_put_index_o,
   output logic [4:0] event_get_index_o,
   output logic [13:0] fifo0_start_o,
   output logic [13:0] fifo1_start_o,
   output logic [13:0] rx_buffer_start_o,
   output logic [13:0] event_fifo_start_o,
   output logic [13:0] tx_buffer_start_o,
   output logic [13:0] std_filter_start_o,
   output logic [13:0] ext_filter_start_o,
   output logic bit_error_uncorrected_flag_o
);
   localparam int AW = cmr_pkg::RAM_AW;
   // config registers, start field and count field
   logic [31:0] std_flt_reg;
   logic [31:0] ext_flt_reg;
   logic [31:0] fifo0_reg;
   logic [31:0] fifo1_reg;
   logic [31:0] rxbuf_reg;
   logic [31:0] evcfg_reg;
   logic [31:0] txbuf_reg;
   logic [31:0] rx_element_size_config_reg;
   logic [31:0] tx_element_size_config_reg;
   logic [AW-1:0] ram_ptr_reg; // software access pointer
   logic [4:0] ack_index_reg;
   logic [4:0] event_get_index_reg;
   logic [4:0] event_put_index_reg;
   logic [5:0] event_fill_level_reg;
   logic beu_reg;
   logic [31:0] rdata_reg;
   logic ram_rd_pend_reg;

   // write decodes
   wire wr_std = wr_i && (addr_i == cmr_pkg::OFF_STD_FLT);
   wire wr_ext = wr_i && (addr_i == cmr_pkg::OFF_EXT_FLT);
   wire wr_f0 = wr_i && (addr_i == cmr_pkg::OFF_FIFO0);
   wire wr_f1 = wr_i && (addr_i == cmr_pkg::OFF_FIFO1);
   wire wr_rb = wr_i && (addr_i == cmr_pkg::OFF_RXBUF);
   wire wr_ev = wr_i && (addr_i == cmr_pkg::OFF_EVCFG);
   wire wr_tb = wr_i && (addr_i == cmr_pkg::OFF_TXBUF);
   wire wr_rxesc = wr_i && (addr_i == cmr_pkg::OFF_RXESC);
   wire wr_txesc = wr_i && (addr_i == cmr_pkg::OFF_TXESC);
   wire wr_ack = wr_i && (addr_i == cmr_pkg::OFF_EVACK);
   wire wr_irq = wr_i && (addr_i == cmr_pkg::OFF_IRQ);
   wire wr_ptr = wr_i && (addr_i == cmr_pkg::OFF_RAM_ADDR);
   wire wr_data = wr_i && (addr_i == cmr_pkg::OFF_RAM_DATA);
   wire rd_data = rd_i && (addr_i == cmr_pkg::OFF_RAM_DATA);

   // event fifo size, values over 32 act as 32
   wire [5:0] ev_size_raw = evcfg_reg[cmr_pkg::EFS_MSB:cmr_pkg::CNT_LSB];
   wire [5:0] ev_size = (ev_size_raw > 6'(cmr_pkg::EF_MAX)) ? 6'(cmr_pkg::EF_MAX) : ev_size_raw;
   // ack index plus one, wrapping at the last element
   wire ack_last = ({1'b0, wdata_i[cmr_pkg::ACK_MSB:0]} + 6'h01) >= ev_size;
   wire [4:0] ack_next_gi = ack_last ? 5'h00 : (wdata_i[cmr_pkg::ACK_MSB:0] + 5'h01);
   // put index wraps the same way
   wire [4:0] put_next = (({1'b0, event_put_index_reg} + 6'h01) >= ev_size) ? 5'h00 :
                         (event_put_index_reg + 5'h01);
   // fill level from pointers, full when equal and level nonzero
   wire [5:0] fill_from = (ack_next_gi <= event_put_index_reg) ?
                          6'(event_put_index_reg - ack_next_gi) :
                          6'(ev_size - 6'(ack_next_gi) + 6'(event_put_index_reg));
   wire ev_full = (ev_size != 6'h00) && (event_fill_level_reg == ev_size);
   wire ev_push_ok = ev_push_i && !ev_full && (ev_size != 6'h00);

   // data size codes: 0..7 -> 8,12,16,20,24,32,48,64 bytes
   function automatic logic [4:0] ds_words(input logic [2:0] c);
      logic [4:0] w;
      w = 5'h02;
      case (c)
         3'h0: w = 5'h02;
         3'h1: w = 5'h03;
         3'h2: w = 5'h04;
         3'h3: w = 5'h05;
         3'h4: w = 5'h06;
         3'h5: w = 5'h08;
         3'h6: w = 5'h0C;
         default: w = 5'h10;
      endcase
      return w;
   endfunction : ds_words

   // element word counts per section, header plus data
   wire [2:0] fifo0_data_size = rx_element_size_config_reg[cmr_pkg::DS_W-1:0];
   wire [2:0] fifo1_data_size = rx_element_size_config_reg[cmr_pkg::FIFO1_DATA_SIZE_LSB+cmr_pkg::DS_W-1:cmr_pkg::FIFO1_DATA_SIZE_LSB];
   wire [2:0] rx_buffer_data_size = rx_element_size_config_reg[cmr_pkg::RX_BUFFER_DATA_SIZE_LSB+cmr_pkg::DS_W-1:cmr_pkg::RX_BUFFER_DATA_SIZE_LSB];
   wire [2:0] tx_buffer_data_size = tx_element_size_config_reg[cmr_pkg::DS_W-1:0];
   wire [4:0] f0_ew = ds_words(fifo0_data_size) + 5'(cmr_pkg::HDR_WORDS);
   wire [4:0] f1_ew = ds_words(fifo1_data_size) + 5'(cmr_pkg::HDR_WORDS);
   wire [4:0] rb_ew = ds_words(rx_buffer_data_size) + 5'(cmr_pkg::HDR_WORDS);
   wire [4:0] tb_ew = ds_words(tx_buffer_data_size) + 5'(cmr_pkg::HDR_WORDS);
   // counts clipped to each section's maximum
   wire [7:0] n_std = (std_flt_reg[23:16] > 8'h80) ? 8'h80 : std_flt_reg[23:16];
   wire [6:0] n_ext = (ext_flt_reg[22:16] > 7'h40) ? 7'h40 : ext_flt_reg[22:16];
   wire [6:0] n_f0 = (fifo0_reg[22:16] > 7'h40) ? 7'h40 : fifo0_reg[22:16];
   wire [6:0] n_f1 = (fifo1_reg[22:16] > 7'h40) ? 7'h40 : fifo1_reg[22:16];
   wire [6:0] n_rb = (rxbuf_reg[22:16] > 7'h40) ? 7'h40 : rxbuf_reg[22:16];
   wire [5:0] n_tb = (txbuf_reg[21:16] > 6'h20) ? 6'h20 : txbuf_reg[21:16];
   // total words needed; factors widened first so 64 x 18 cannot wrap; overlap never checked
   wire [15:0] words_needed = 16'(n_std) + 16'({n_ext, 1'b0}) + 16'(n_f0) * 16'(f0_ew) +
                              16'(n_f1) * 16'(f1_ew) + 16'(n_rb) * 16'(rb_ew) + 16'({ev_size, 1'b0}) +
                              16'(n_tb) * 16'(tb_ew);

   // ram port: engine has priority over software writes
   wire ram_we = eng_wr_i.we || wr_data;
   wire [AW-1:0] ram_wa = eng_wr_i.we ? eng_wr_i.addr : ram_ptr_reg;
   wire [31:0] ram_wd = eng_wr_i.we ? eng_wr_i.data : wdata_i;
   wire [31:0] ram_q;
   wire ram_perr;

   cmr_ram #(.WORDS(WORDS), .AW(AW)) u_ram (
      .clk_i(clk_i),
      .we_i(ram_we),
      .waddr_i(ram_wa),
      .wdata_i(ram_wd),
      .re_i(rd_data),
      .raddr_i(ram_ptr_reg),
      .rdata_o(ram_q),
      .perr_o(ram_perr)
   );

   // read mux for register reads
   logic [31:0] rmux;
   always_comb begin
      rmux = cmr_pkg::RST_VAL;
      case (addr_i)
         cmr_pkg::OFF_STD_FLT: rmux = std_flt_reg;
         cmr_pkg::OFF_EXT_FLT: rmux = ext_flt_reg;
         cmr_pkg::OFF_FIFO0: rmux = fifo0_reg;
         cmr_pkg::OFF_FIFO1: rmux = fifo1_reg;
         cmr_pkg::OFF_RXBUF: rmux = rxbuf_reg;
         cmr_pkg::OFF_EVCFG: rmux = evcfg_reg;
         cmr_pkg::OFF_TXBUF: rmux = txbuf_reg;
         cmr_pkg::OFF_RXESC: rmux = rx_element_size_config_reg;
         cmr_pkg::OFF_TXESC: rmux = tx_element_size_config_reg;
         cmr_pkg::OFF_EVSTAT: rmux = {7'h00, ev_full, 3'h0, event_put_index_reg, 3'h0,
                                      event_get_index_reg, 2'h0, event_fill_level_reg};
         cmr_pkg::OFF_EVACK: rmux = {27'h0, ack_index_reg};
         cmr_pkg::OFF_IRQ: rmux = {31'h0, beu_reg};
         cmr_pkg::OFF_RAM_ADDR: rmux = 32'(ram_ptr_reg);
         cmr_pkg::OFF_ELEM_SIZE: rmux = {16'h0, words_needed};
         default: rmux = cmr_pkg::RST_VAL; // unmapped reads zero
      endcase
   end

   // config writes; low two bits of start addresses dropped
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         std_flt_reg <= cmr_pkg::RST_VAL;
         ext_flt_reg <= cmr_pkg::RST_VAL;
         fifo0_reg <= cmr_pkg::RST_VAL;
         fifo1_reg <= cmr_pkg::RST_VAL;
         rxbuf_reg <= cmr_pkg::RST_VAL;
         evcfg_reg <= cmr_pkg::RST_VAL;
         txbuf_reg <= cmr_pkg::RST_VAL;
         rx_element_size_config_reg <= cmr_pkg::RST_VAL;
         tx_element_size_config_reg <= cmr_pkg::RST_VAL;
      end else begin
         if (wr_std) std_flt_reg <= {wdata_i[31:2], 2'b00};
         if (wr_ext) ext_flt_reg <= {wdata_i[31:2], 2'b00};
         if (wr_f0) fifo0_reg <= {wdata_i[31:2], 2'b00};
         if (wr_f1) fifo1_reg <= {wdata_i[31:2], 2'b00};
         if (wr_rb) rxbuf_reg <= {wdata_i[31:2], 2'b00};
         if (wr_ev) evcfg_reg <= {wdata_i[31:2], 2'b00};
         if (wr_tb) txbuf_reg <= {wdata_i[31:2], 2'b00};
         if (wr_rxesc) rx_element_size_config_reg <= wdata_i;
         if (wr_txesc) tx_element_size_config_reg <= wdata_i;
      end
   end

   // event fifo pointers and fill level
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ack_index_reg <= 5'h00;
         event_get_index_reg <= 5'h00;
         event_put_index_reg <= 5'h00;
         event_fill_level_reg <= 6'h00;
      end else if (wr_ev) begin
         // reconfiguring empties the fifo
         event_get_index_reg <= 5'h00;
         event_put_index_reg <= 5'h00;
         event_fill_level_reg <= 6'h00;
      end else begin
         if (wr_ack) begin
            ack_index_reg <= wdata_i[cmr_pkg::ACK_MSB:0];
            event_get_index_reg <= ack_next_gi;
         end
         if (ev_push_ok) event_put_index_reg <= put_next;
         // a push in the ack cycle counts on top of the new level
         if (wr_ack) begin
            event_fill_level_reg <= fill_from + (ev_push_ok ? 6'h01 : 6'h00);
         end else if (ev_push_ok) begin
            event_fill_level_reg <= event_fill_level_reg + 6'h01;
         end
      end
   end

   // software ram pointer, parity flag, read data
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ram_ptr_reg <= '0;
         beu_reg <= 1'b0;
         rdata_reg <= cmr_pkg::RST_VAL;
         ram_rd_pend_reg <= 1'b0;
      end else begin
         if (wr_ptr) ram_ptr_reg <= wdata_i[AW-1:0];
         else if ((wr_data && !eng_wr_i.we) || rd_data) ram_ptr_reg <= ram_ptr_reg + 1'b1;
         // set wins over write-one-to-clear
         if (ram_perr) beu_reg <= 1'b1;
         else if (wr_irq && wdata_i[cmr_pkg::BEU_BIT]) beu_reg <= 1'b0;
         ram_rd_pend_reg <= rd_data;
         rdata_reg <= rmux;
      end
   end
   // ram data bypasses the register in the answer cycle
   assign rdata_o = ram_rd_pend_reg ? ram_q : rdata_reg;

   // element header packing for the engine
   wire [28:0] id_place = hdr0_i.extended_id_flag ? hdr0_i.id : {hdr0_i.id[10:0], 18'h0};
   wire [31:0] h1 = {hdr1_i.nonmatching_accepted, hdr1_i.filter_index, 2'b00, hdr1_i.fdf,
                     hdr1_i.brs, hdr1_i.dlc, ts_cnt_i};
   // dlc to byte count
   logic [6:0] dlc_b;
   always_comb begin
      dlc_b = 7'h08;
      case (hdr1_i.dlc)
         4'h9: dlc_b = 7'h0C;
         4'hA: dlc_b = 7'h10;
         4'hB: dlc_b = 7'h14;
         4'hC: dlc_b = 7'h18;
         4'hD: dlc_b = 7'h20;
         4'hE: dlc_b = 7'h30;
         4'hF: dlc_b = 7'h40;
         default: dlc_b = {3'h0, hdr1_i.dlc};
      endcase
      if (!hdr1_i.fdf && hdr1_i.dlc > 4'h8) dlc_b = 7'h08;
   end

   // header words registered; data words go straight from eng_wr_i, byte 0 in bits 7:0
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         hdr0_word_o <= cmr_pkg::RST_VAL;
         hdr1_word_o <= cmr_pkg::RST_VAL;
         dlc_bytes_o <= 7'h00;
      end else begin
         hdr0_word_o <= {hdr0_i.esi, hdr0_i.extended_id_flag, hdr0_i.rtr, id_place};
         hdr1_word_o <= h1;
         dlc_bytes_o <= dlc_b;
      end
   end

   assign event_put_index_o = event_put_index_reg;
   assign event_get_index_o = event_get_index_reg;
   assign std_filter_start_o = std_flt_reg[cmr_pkg::SA_MSB:cmr_pkg::SA_LSB];
   assign ext_filter_start_o = ext_flt_reg[cmr_pkg::SA_MSB:cmr_pkg::SA_LSB];
   assign fifo0_start_o = fifo0_reg[cmr_pkg::SA_MSB:cmr_pkg::SA_LSB];
   assign fifo1_start_o = fifo1_reg[cmr_pkg::SA_MSB:cmr_pkg::SA_LSB];
   assign rx_buffer_start_o = rxbuf_reg[cmr_pkg::SA_MSB:cmr_pkg::SA_LSB];
   assign event_fifo_start_o = evcfg_reg[cmr_pkg::SA_MSB:cmr_pkg::SA_LSB];
   assign tx_buffer_start_o = txbuf_reg[cmr_pkg::SA_MSB:cmr_pkg::SA_LSB];
   assign bit_error_uncorrected_flag_o = beu_reg;
endmodule : cmr_top

// ==== shared/cmr_pkg.sv ====
// package for the can fd message ram layout block
package cmr_pkg;
   // register offsets (byte addresses, one word each)
   localparam logic [11:0] OFF_STD_FLT = 12'h000;
   localparam logic [11:0] OFF_EXT_FLT = 12'h004;
   localparam logic [11:0] OFF_FIFO0 = 12'h008;
   localparam logic [11:0] OFF_FIFO1 = 12'h00C;
   localparam logic [11:0] OFF_RXBUF = 12'h010;
   localparam logic [11:0] OFF_EVCFG = 12'h014;
   localparam logic [11:0] OFF_TXBUF = 12'h018;
   localparam logic [11:0] OFF_RXESC = 12'h01C;
   localparam logic [11:0] OFF_TXESC = 12'h020;
   localparam logic [11:0] OFF_EVSTAT = 12'h024;
   localparam logic [11:0] OFF_EVACK = 12'h028;
   localparam logic [11:0] OFF_IRQ = 12'h02C;
   localparam logic [11:0] OFF_RAM_ADDR = 12'h030;
   localparam logic [11:0] OFF_RAM_DATA = 12'h034;
   localparam logic [11:0] OFF_ELEM_SIZE = 12'h038;
   // field positions
   localparam int SA_LSB = 2;
   localparam int SA_MSB = 15;
   localparam int CNT_LSB = 16;
   localparam int EFS_MSB = 21;
   localparam int ACK_MSB = 4;
   localparam int GI_LSB = 8;
   localparam int DS_W = 3;
   localparam int FIFO1_DATA_SIZE_LSB = 4;
   localparam int RX_BUFFER_DATA_SIZE_LSB = 8;
   localparam int BEU_BIT = 0;
   // sizes
   localparam int RAM_WORDS = 1600;
   localparam int RAM_AW = 11;
   localparam int EF_MAX = 32;
   localparam int HDR_WORDS = 2;
   localparam logic [31:0] RST_VAL = 32'h0000_0000;
   // engine write port to the ram
   typedef struct packed {
      logic we;
      logic [RAM_AW-1:0] addr;
      logic [31:0] data;
   } cmr_wr_s;
   // element header words
   typedef struct packed {
      logic esi;
      logic extended_id_flag;
      logic rtr;
      logic [28:0] id;
   } cmr_hdr0_s;
   typedef struct packed {
      logic nonmatching_accepted;
      logic [6:0] filter_index;
      logic [1:0] rsvd;
      logic fdf;
      logic brs;
      logic [3:0] dlc;
      logic [15:0] rx_timestamp;
   } cmr_hdr1_s;
endpackage : cmr_pkg

// ==== rtl/cmr_ram.sv ====
`timescale 1ns/1ps
// message ram: 32-bit words plus one parity bit each
module cmr_ram #(
   parameter int WORDS = cmr_pkg::RAM_WORDS,
   parameter int AW = cmr_pkg::RAM_AW
) (
   input wire logic clk_i,
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [31:0] wdata_i,
   input wire logic re_i,
   input wire logic [AW-1:0] raddr_i,
   output logic [31:0] rdata_o,
   output logic perr_o
);
   // parity stored beside each data word
   logic [32:0] mem [WORDS];
   logic [32:0] q_reg;
   logic rv_reg;
   // no reset on the array: contents undefined until software fills it
   always_ff @(posedge clk_i) begin
      if (we_i && (int'(waddr_i) < WORDS)) begin
         mem[waddr_i] <= {^wdata_i, wdata_i};
      end
      if (re_i && (int'(raddr_i) < WORDS)) begin
         q_reg <= mem[raddr_i];
      end
      rv_reg <= re_i;
   end
   assign rdata_o = q_reg[31:0];
   // mismatch seen only on a real read
   assign perr_o = rv_reg && (^q_reg[31:0] != q_reg[32]);
endmodule : cmr_ram

// ==== test/cmr_checker.sv ====
// assertion checker for the message ram layout block
`timescale 1ns/1ps
module cmr_checker (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [11:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic ev_push_i,
   input wire logic [15:0] ts_cnt_i,
   input wire cmr_pkg::cmr_hdr0_s hdr0_i,
   input wire cmr_pkg::cmr_hdr1_s hdr1_i,
   input wire logic [31:0] hdr0_word_o,
   input wire logic [31:0] hdr1_word_o,
   input wire logic [6:0] dlc_bytes_o,
   input wire logic [4:0] event_put_index_o,
   input wire logic [4:0] event_get_index_o,
   input wire logic [13:0] fifo0_start_o,
   input wire logic bit_error_uncorrected_flag_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // shadow of the event fifo size, clamped at 32 as the device does
   logic [5:0] efs_reg;
   wire logic wr_ack = wr_i && addr_i == cmr_pkg::OFF_EVACK;
   wire logic wr_cfg = wr_i && addr_i == cmr_pkg::OFF_EVCFG;
   wire logic ack_wrap = ({1'b0, wdata_i[4:0]} + 6'h01) >= efs_reg;
   wire logic [4:0] ack_exp = ack_wrap ? 5'h00 : wdata_i[4:0] + 5'h01;
   wire logic irq_clr = wr_i && addr_i == cmr_pkg::OFF_IRQ && wdata_i[0];
   // size shadow follows config writes only
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) efs_reg <= 6'h00;
      else if (wr_cfg) efs_reg <= (wdata_i[21:16] > 6'h20) ? 6'h20 : wdata_i[21:16];
   end
   // byte count of a length code, fd codes above 8 grow
   function automatic logic [6:0] dlc_len(input logic fd, input logic [3:0] c);
      if (c <= 4'h8) return {3'h0, c};
      if (!fd) return 7'h08;
      case (c)
         4'h9: return 7'h0C;
         4'hA: return 7'h10;
         4'hB: return 7'h14;
         4'hC: return 7'h18;
         4'hD: return 7'h20;
         4'hE: return 7'h30;
         default: return 7'h40;
      endcase
   endfunction : dlc_len
   ack_get_load_a: assert property (wr_ack |=> event_get_index_o == $past(ack_exp))
      else $error("get index not loaded from acknowledge");
   ack_get_wrap_a: assert property (wr_ack && ack_wrap |=> event_get_index_o == 5'h00)
      else $error("get index did not wrap");
   cfg_ptr_clear_a: assert property (wr_cfg |=> event_put_index_o == 5'h00 && event_get_index_o == 5'h00)
      else $error("pointers not cleared by config write");
   empty_push_hold_a: assert property (ev_push_i && efs_reg == 6'h00 && !wr_cfg |=>
      $stable(event_put_index_o))
      else $error("put index moved with size zero");
   start_word_a: assert property (wr_i && addr_i == cmr_pkg::OFF_FIFO0 |=>
      fifo0_start_o == $past(wdata_i[15:2]))
      else $error("start address not taken from bits 15:2");
   ts_low_half_a: assert property (1'b1 |=> hdr1_word_o[15:0] == $past(ts_cnt_i))
      else $error("timestamp missing from second word");
   hdr0_flags_a: assert property (1'b1 |=> hdr0_word_o[31:29] ==
      $past({hdr0_i.esi, hdr0_i.extended_id_flag, hdr0_i.rtr}))
      else $error("first word flags misplaced");
   std_id_place_a: assert property (!hdr0_i.extended_id_flag |=>
      hdr0_word_o[28:0] == {$past(hdr0_i.id[10:0]), 18'h00000})
      else $error("standard identifier not in bits 28:18");
   hdr1_fields_a: assert property (1'b1 |=> hdr1_word_o[31:16] == $past({hdr1_i.nonmatching_accepted,
      hdr1_i.filter_index, 2'b00, hdr1_i.fdf, hdr1_i.brs, hdr1_i.dlc}))
      else $error("second word fields misplaced");
   dlc_bytes_a: assert property (1'b1 |=> dlc_bytes_o == dlc_len($past(hdr1_i.fdf), $past(hdr1_i.dlc)))
      else $error("length code byte count wrong");
   beu_sticky_a: assert property (bit_error_uncorrected_flag_o && !irq_clr |=> bit_error_uncorrected_flag_o)
      else $error("parity flag dropped without clear");
endmodule : cmr_checker
bind cmr_top cmr_checker i_chk (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .ev_push_i(ev_push_i), .ts_cnt_i(ts_cnt_i), .hdr0_i(hdr0_i), .hdr1_i(hdr1_i), .hdr0_word_o(hdr0_word_o),
   .hdr1_word_o(hdr1_word_o), .dlc_bytes_o(dlc_bytes_o), .event_put_index_o(event_put_index_o),
   .event_get_index_o(event_get_index_o), .fifo0_start_o(fifo0_start_o),
   .bit_error_uncorrected_flag_o(bit_error_uncorrected_flag_o));

// ==== test/cmr_engine_model.sv ====
// protocol engine model: ram writes, event pushes, headers, timestamp
`timescale 1ns/1ps
module cmr_engine_model (
   input wire logic clk_i,
   input wire logic rstn_i,
   output cmr_pkg::cmr_wr_s eng_wr_o,
   output logic ev_push_o,
   output logic [15:0] ts_cnt_o,
   output cmr_pkg::cmr_hdr0_s hdr0_o,
   output cmr_pkg::cmr_hdr1_s hdr1_o
);
   // quiet engine at time zero
   initial begin
      eng_wr_o = '0;
      ev_push_o = 1'b0;
      hdr0_o = '0;
      hdr1_o = '0;
   end
   // timestamp counter, odd step so every bit toggles soon
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) ts_cnt_o <= 16'h0000;
      else ts_cnt_o <= ts_cnt_o + 16'h0013;
   end
   // one stored event element per pulse, pulses spaced a cycle apart
   task automatic push(input int n);
      repeat (n) begin
         @(posedge clk_i);
         ev_push_o <= 1'b1;
         @(posedge clk_i);
         ev_push_o <= 1'b0;
      end
      // let the last push land before the caller looks at the pointers
      #1;
   endtask : push
   // single word store into the ram, full 32-bit word
   task automatic ram_write(input logic [10:0] a, input logic [31:0] d);
      @(posedge clk_i);
      eng_wr_o <= '{we: 1'b1, addr: a, data: d};
      @(posedge clk_i);
      eng_wr_o.we <= 1'b0;
   endtask : ram_write
   // present header fields of a received frame
   task automatic frame(input cmr_pkg::cmr_hdr0_s h0, input cmr_pkg::cmr_hdr1_s h1);
      @(posedge clk_i);
      hdr0_o <= h0;
      hdr1_o <= h1;
   endtask : frame
endmodule : cmr_engine_model

// ==== test/cmr_top_bench.sv ====
// self-checking bench for the message ram layout block
`timescale 1ns/1ps
module cmr_top_bench;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [11:0] addr_i = 12'h000;
   logic [31:0] wdata_i = 32'h0000_0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [31:0] rdata_o, h0w, h1w, d;
   cmr_pkg::cmr_wr_s eng_wr;
   logic ev_push;
   logic [15:0] ts, t;
   cmr_pkg::cmr_hdr0_s hdr0, h0;
   cmr_pkg::cmr_hdr1_s hdr1, h1;
   logic [6:0] dlc_bytes;
   logic [4:0] put_idx, get_idx;
   logic [13:0] sa [7];
   logic bit_error_uncorrected_flag;
   int fail_count = 0;
   int n_checks = 0;
   // fd byte counts for codes 9 to 15
   logic [6:0] fd_len [7] = '{7'h0C, 7'h10, 7'h14, 7'h18, 7'h20, 7'h30, 7'h40};
   cmr_top i_cmr_top (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .eng_wr_i(eng_wr), .ev_push_i(ev_push), .ts_cnt_i(ts), .hdr0_i(hdr0),
      .hdr1_i(hdr1), .hdr0_word_o(h0w), .hdr1_word_o(h1w), .dlc_bytes_o(dlc_bytes),
      .event_put_index_o(put_idx), .event_get_index_o(get_idx), .std_filter_start_o(sa[0]),
      .ext_filter_start_o(sa[1]), .fifo0_start_o(sa[2]), .fifo1_start_o(sa[3]), .rx_buffer_start_o(sa[4]),
      .event_fifo_start_o(sa[5]), .tx_buffer_start_o(sa[6]), .bit_error_uncorrected_flag_o(bit_error_uncorrected_flag));
   cmr_engine_model i_cmr_engine_model (.clk_i(clk_i), .rstn_i(rstn_i), .eng_wr_o(eng_wr),
      .ev_push_o(ev_push), .ts_cnt_o(ts), .hdr0_o(hdr0), .hdr1_o(hdr1));
   // 8 ns clock
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   // compare and count, unknown bits match only unknown bits
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one-cycle write strobe
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      #1;
   endtask : wr
   // one-cycle read strobe, data taken in the following cycle
   task automatic rd(input logic [11:0] a, output logic [31:0] v);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask : rd
   // reset values and unmapped place
   task automatic t_reset();
      rd(cmr_pkg::OFF_EVACK, d);
      chk(d, 32'h0000_0000);
      rd(cmr_pkg::OFF_EVSTAT, d);
      chk(d, 32'h0000_0000);
      wr(12'h0FC, 32'hFFFF_FFFF);
      rd(12'h0FC, d);
      chk(d, 32'h0000_0000);
      $display("test reset values done");
   endtask : t_reset
   // event fifo acknowledge, fill level and wrap
   task automatic t_event();
      wr(cmr_pkg::OFF_EVCFG, 32'h0008_0102);
      chk({18'h0, sa[5]}, 32'h0000_0040);
      i_cmr_engine_model.push(5);
      rd(cmr_pkg::OFF_EVSTAT, d);
      chk(d, 32'h0005_0005);
      wr(cmr_pkg::OFF_EVACK, 32'h0000_0003);
      chk({27'h0, get_idx}, 32'h0000_0004);
      rd(cmr_pkg::OFF_EVSTAT, d);
      chk(d, 32'h0005_0401);
      i_cmr_engine_model.push(3);
      chk({27'h0, put_idx}, 32'h0000_0000);
      wr(cmr_pkg::OFF_EVACK, 32'h0000_0007);
      chk({27'h0, get_idx}, 32'h0000_0000);
      wr(cmr_pkg::OFF_EVCFG, 32'h0000_0100);
      i_cmr_engine_model.push(2);
      chk({27'h0, put_idx}, 32'h0000_0000);
      $display("test event fifo done");
   endtask : t_event
   // section starts, any order, low bits dropped
   task automatic t_starts();
      logic [31:0] v;
      for (int k = 0; k < 7; k++) begin
         v = 32'h0000_7FF3 - 32'h0000_0404 * k;
         wr(12'(4 * k), v);
         chk({18'h0, sa[k]}, {18'h0, v[15:2]});
         rd(12'(4 * k), d);
         chk({16'h0, d[15:0]}, {16'h0, v[15:2], 2'b00});
      end
      $display("test section starts done");
   endtask : t_starts
   // ram words from software and engine, no false parity error
   task automatic t_ram();
      wr(cmr_pkg::OFF_RAM_ADDR, 32'h0000_063F);
      wr(cmr_pkg::OFF_RAM_DATA, 32'hA5C3_0F81);
      wr(cmr_pkg::OFF_RAM_ADDR, 32'h0000_063F);
      rd(cmr_pkg::OFF_RAM_DATA, d);
      chk(d, 32'hA5C3_0F81);
      i_cmr_engine_model.ram_write(11'h010, 32'h1234_5678);
      wr(cmr_pkg::OFF_RAM_ADDR, 32'h0000_0010);
      rd(cmr_pkg::OFF_RAM_DATA, d);
      chk(d, 32'h1234_5678);
      chk({31'h0, bit_error_uncorrected_flag}, 32'h0000_0000);
      wr(cmr_pkg::OFF_IRQ, 32'h0000_0001);
      chk({31'h0, bit_error_uncorrected_flag}, 32'h0000_0000);
      // fifo 0 of 127 asked elements clipped to 64, each 2 header plus 16 data words
      wr(cmr_pkg::OFF_RXESC, 32'h0000_0007);
      wr(cmr_pkg::OFF_FIFO0, 32'h007F_0000);
      rd(cmr_pkg::OFF_ELEM_SIZE, d);
      chk(d, 32'h0000_0480);
      $display("test message ram done");
   endtask : t_ram
   // header words and length codes, classic and fd
   task automatic t_hdr();
      for (int c = 0; c < 32; c++) begin
         h0 = '{esi: c[0], extended_id_flag: c[3], rtr: c[1], id: 29'h1ABC_DE00 ^ 29'(c)};
         h1 = '{nonmatching_accepted: c[4], filter_index: 7'(c + 64), rsvd: 2'b00, fdf: c[4], brs: c[2],
            dlc: c[3:0], rx_timestamp: 16'h0000};
         i_cmr_engine_model.frame(h0, h1);
         #1 t = ts;
         @(posedge clk_i);
         #1;
         chk(h0w, {h0[31:29], c[3] ? h0.id : {h0.id[10:0], 18'h00000}});
         chk(h1w, {h1[31:16], t});
         chk({25'h0, dlc_bytes}, {25'h0, (c[3:0] <= 8) ? 7'(c[3:0]) : c[4] ? fd_len[c[3:0] - 9] : 7'h08});
      end
      $display("test element headers done");
   endtask : t_hdr
   // verdict and end of run
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : results
   // main sequence
   initial begin
      repeat (6) @(posedge clk_i);
      rstn_i <= 1'b1;
      t_reset();
      t_event();
      t_starts();
      t_ram();
      t_hdr();
      results();
   end
   // hang guard, far beyond the roughly 160 cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      results();
   end
endmodule : cmr_top_bench
